// [hdl/block_seq_pkg.sv]
// Constants, types and the software map of the fieldbus block sequencer.
// Assumes one 25 MHz APB clock domain and an APB master that honours pready.
// What this block does
// - Linked blocks run without further host commands
// - Run attribute 1 of the requested block
// - Follow attribute 2 links until zero
// - Execution flag high while the sequence runs
// - Command block instances 1 through 255 stored
// - Class, instance, attribute address each access
// - Position class attribute 13 returns position
// - Request header and service byte layout
// - Response echoes header, service with bit 7
// - Get single returns acceleration attribute 8
// - Assembly and connection instance roles fixed
// - Requests routed by class identifier
// - Block changes refused while busy or alarmed
package block_seq_pkg;

   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] CMD_OFS      = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] REQ_HEAD_OFS = 8'h08;
   localparam logic [7:0] REQ_ATTR_OFS = 8'h0c;
   localparam logic [7:0] REQ_DATA_OFS = 8'h10;
   localparam logic [7:0] REQ_GO_OFS   = 8'h14;
   localparam logic [7:0] RSP_HEAD_OFS = 8'h18;
   localparam logic [7:0] RSP_DATA_OFS = 8'h1c;

   // ==========================================================
   // Polled command byte 0 bit positions
   localparam int START_BLOCK_BIT = 1;
   localparam int HARD_STOP_BIT   = 5;
   localparam int VALID_DATA_BIT  = 6;

   // ==========================================================
   // Classes, services, attributes, instances
   localparam logic [7:0] CLS_ASSEMBLY = 8'h04;
   localparam logic [7:0] CLS_CONN     = 8'h05;
   localparam logic [7:0] CLS_POS_CTRL = 8'h25;
   localparam logic [7:0] CLS_CMD_BLK  = 8'h27;
   localparam logic [7:0] SVC_GET_SINGLE = 8'h0e;
   localparam logic [7:0] SVC_SET_SINGLE = 8'h10;
   localparam logic [7:0] ATTR_ACCEL    = 8'h08;
   localparam logic [7:0] ATTR_CUR_POS  = 8'h0d;
   localparam logic [7:0] ATTR_BLK_CODE = 8'h01;
   localparam logic [7:0] ATTR_BLK_LINK = 8'h02;
   localparam logic [7:0] ATTR_BLK_PAR  = 8'h03;
   localparam logic [7:0] ATTR_ASM_DATA = 8'h03;
   localparam logic [7:0] ATTR_CONN_ST  = 8'h01;
   localparam logic [7:0] INST_ONE      = 8'h01;
   localparam logic [7:0] INST_RSP_ASM  = 8'h01;
   localparam logic [7:0] INST_CMD_ASM  = 8'h02;
   localparam logic [7:0] INST_EXPL_CON = 8'h01;
   localparam logic [7:0] INST_POLL_CON = 8'h02;
   localparam logic [7:0] LINK_END      = 8'h00;
   localparam logic [7:0] CONN_ESTABLISHED = 8'h03;
   localparam logic [7:0] RSP_FLAG      = 8'h80;

   // ==========================================================
   // Reset values and counts
   localparam logic [31:0] ACCEL_RST  = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RST   = 8'h00;
   localparam int          MAX_BLOCKS = 255;
   localparam logic [2:0]  LEN_BYTE   = 3'd1;
   localparam logic [2:0]  LEN_HALF   = 3'd2;
   localparam logic [2:0]  LEN_WORD   = 3'd4;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} seq_e;

   // Command issued to the motion engine
   typedef struct packed {
      logic        valid;
      logic [7:0]  blk;
      logic [7:0]  code;
      logic [31:0] param;
   } motion_cmd_s;

   // Explicit request as assembled by software
   typedef struct packed {
      logic [7:0]  hdr;
      logic [7:0]  svc;
      logic [7:0]  cls;
      logic [7:0]  inst;
      logic [7:0]  attr;
      logic [31:0] data;
   } req_s;

   // Explicit response
   typedef struct packed {
      logic [7:0]  hdr;
      logic [7:0]  svc;
      logic [2:0]  len;
      logic        err;
      logic [31:0] data;
   } rsp_s;

endpackage

// [hdl/fieldbus_block_sequencer.sv]
// Fieldbus command side: polled start of linked command blocks and explicit
// attribute requests, all reached through an APB slave with one wait state.
// Assumes a motion engine that pulses motion_done when an issued block ends.
`timescale 1ns/1ns
module fieldbus_block_sequencer #(
   parameter int NUM_BLOCKS = 255
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic [31:0]                cur_position,
   input  wire logic                       alarm,
   input  wire logic                       motion_done,
   output block_seq_pkg::motion_cmd_s      motion_cmd,
   output logic                            block_busy
);
   import block_seq_pkg::*;

   // ==========================================================
   // Parameter check
   initial begin
      if (NUM_BLOCKS < 1 || NUM_BLOCKS > MAX_BLOCKS) begin
         $error("NUM_BLOCKS out of range");
      end
   end

   typedef struct packed {
      seq_e        seq;
      logic [7:0]  cmd0;
      logic [7:0]  blk_num;
      logic [7:0]  cur_blk;
      logic        exec;
      motion_cmd_s mc;
      logic [31:0] accel;
      req_s        req;
      rsp_s        rsp;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // Command block store, instance 0 unused
   logic [7:0]  code_mem [1:NUM_BLOCKS];
   logic [7:0]  link_mem [1:NUM_BLOCKS];
   logic [31:0] par_mem  [1:NUM_BLOCKS];

   logic        apb_wr;
   logic        apb_rd_prep;
   logic        go;
   logic        start_req;
   logic        blk_ok;
   logic        mem_we;
   logic [7:0]  mem_attr;
   logic [7:0]  cur_link;
   logic [31:0] rd_val;
   logic        rd_bad;

   // Write lands only on the edge that completes the access phase
   assign apb_wr      = psel && penable && pwrite && st_r.pready;
   assign apb_rd_prep = psel && penable && !st_r.pready;
   assign go          = apb_wr && (paddr == REQ_GO_OFS);
   assign blk_ok      = (st_r.req.inst != BYTE_RST) && (32'(st_r.req.inst) <= NUM_BLOCKS);
   assign cur_link    = link_mem[st_r.cur_blk];

   // Start on rising start bit
   // Host keeps valid set before raising start; a start without valid is ignored
   assign start_req = apb_wr && (paddr == CMD_OFS) && pwdata[VALID_DATA_BIT]
                      && pwdata[START_BLOCK_BIT] && !st_r.cmd0[START_BLOCK_BIT]
                      && (pwdata[15:8] != BYTE_RST) && (32'(pwdata[15:8]) <= NUM_BLOCKS);

   // ==========================================================
   // Read mux, prepared one cycle before pready so prdata is a flop
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_bad = 1'b0;
      unique case (paddr)
         CMD_OFS:      rd_val = {16'h0000, st_r.blk_num, st_r.cmd0};
         STATUS_OFS:   rd_val = {16'h0000, st_r.cur_blk, 7'h00, st_r.exec};
         REQ_HEAD_OFS: rd_val = {st_r.req.inst, st_r.req.cls, st_r.req.svc, st_r.req.hdr};
         REQ_ATTR_OFS: rd_val = {24'h000000, st_r.req.attr};
         REQ_DATA_OFS: rd_val = st_r.req.data;
         REQ_GO_OFS:   rd_val = 32'h0000_0000;
         RSP_HEAD_OFS: rd_val = {7'h00, st_r.rsp.err, 5'h00, st_r.rsp.len, st_r.rsp.svc, st_r.rsp.hdr};
         RSP_DATA_OFS: rd_val = st_r.rsp.data;
         default:      rd_bad = 1'b1;
      endcase
   end

   // ==========================================================
   // Next state: APB, request decode, sequencer
   always_comb begin
      st_nxt     = st_r;
      mem_we     = 1'b0;
      mem_attr   = BYTE_RST;
      st_nxt.mc.valid = 1'b0;
      st_nxt.pready   = apb_rd_prep;
      // Unmapped writes are dropped silently; only reads flag an error
      st_nxt.pslverr  = apb_rd_prep && !pwrite && rd_bad;
      if (apb_rd_prep) begin
         st_nxt.prdata = rd_val;
      end

      // Register writes
      if (apb_wr) begin
         unique case (paddr)
            CMD_OFS: begin
               st_nxt.cmd0    = pwdata[7:0];
               st_nxt.blk_num = pwdata[15:8];
            end
            REQ_HEAD_OFS: begin
               st_nxt.req.hdr  = pwdata[7:0];
               st_nxt.req.svc  = pwdata[15:8];
               st_nxt.req.cls  = pwdata[23:16];
               st_nxt.req.inst = pwdata[31:24];
            end
            REQ_ATTR_OFS: st_nxt.req.attr = pwdata[7:0];
            REQ_DATA_OFS: st_nxt.req.data = pwdata;
            default: ;
         endcase
      end

      // Explicit request processing
      if (go) begin
         st_nxt.rsp.hdr  = st_r.req.hdr;
         st_nxt.rsp.svc  = RSP_FLAG | st_r.req.svc;
         st_nxt.rsp.len  = 3'd0;
         st_nxt.rsp.data = 32'h0000_0000;
         st_nxt.rsp.err  = 1'b0;
         if (st_r.req.hdr[7] || st_r.req.svc[7]) begin
            st_nxt.rsp.err = 1'b1;
         end else begin
            unique case (st_r.req.cls)
               CLS_POS_CTRL: begin
                  if (st_r.req.inst != INST_ONE) begin
                     st_nxt.rsp.err = 1'b1;
                  end else if (st_r.req.attr == ATTR_ACCEL && st_r.req.svc == SVC_GET_SINGLE) begin
                     st_nxt.rsp.data = st_r.accel;
                     st_nxt.rsp.len  = LEN_WORD;
                  end else if (st_r.req.attr == ATTR_ACCEL && st_r.req.svc == SVC_SET_SINGLE) begin
                     st_nxt.accel = st_r.req.data;
                  end else if (st_r.req.attr == ATTR_CUR_POS && st_r.req.svc == SVC_GET_SINGLE) begin
                     st_nxt.rsp.data = cur_position;
                     st_nxt.rsp.len  = LEN_WORD;
                  end else begin
                     st_nxt.rsp.err = 1'b1;
                  end
               end
               CLS_CMD_BLK: begin
                  if (!blk_ok) begin
                     st_nxt.rsp.err = 1'b1;
                  end else if (st_r.req.svc == SVC_GET_SINGLE) begin
                     unique case (st_r.req.attr)
                        ATTR_BLK_CODE: begin
                           st_nxt.rsp.data = {24'h000000, code_mem[st_r.req.inst]};
                           st_nxt.rsp.len  = LEN_BYTE;
                        end
                        ATTR_BLK_LINK: begin
                           st_nxt.rsp.data = {24'h000000, link_mem[st_r.req.inst]};
                           st_nxt.rsp.len  = LEN_BYTE;
                        end
                        ATTR_BLK_PAR: begin
                           st_nxt.rsp.data = par_mem[st_r.req.inst];
                           st_nxt.rsp.len  = LEN_WORD;
                        end
                        default: st_nxt.rsp.err = 1'b1;
                     endcase
                  end else if (st_r.req.svc == SVC_SET_SINGLE) begin
                     if (st_r.exec || alarm || st_r.req.attr == BYTE_RST || st_r.req.attr > ATTR_BLK_PAR) begin
                        st_nxt.rsp.err = 1'b1;
                     end else begin
                        mem_we   = 1'b1;
                        mem_attr = st_r.req.attr;
                     end
                  end else begin
                     st_nxt.rsp.err = 1'b1;
                  end
               end
               CLS_ASSEMBLY: begin
                  if (st_r.req.svc != SVC_GET_SINGLE || st_r.req.attr != ATTR_ASM_DATA) begin
                     st_nxt.rsp.err = 1'b1;
                  end else if (st_r.req.inst == INST_RSP_ASM) begin
                     st_nxt.rsp.data = {16'h0000, st_r.cur_blk, 7'h00, st_r.exec};
                     st_nxt.rsp.len  = LEN_HALF;
                  end else if (st_r.req.inst == INST_CMD_ASM) begin
                     st_nxt.rsp.data = {16'h0000, st_r.blk_num, st_r.cmd0};
                     st_nxt.rsp.len  = LEN_HALF;
                  end else begin
                     st_nxt.rsp.err = 1'b1;
                  end
               end
               CLS_CONN: begin
                  if (st_r.req.svc == SVC_GET_SINGLE && st_r.req.attr == ATTR_CONN_ST
                      && (st_r.req.inst == INST_EXPL_CON || st_r.req.inst == INST_POLL_CON)) begin
                     st_nxt.rsp.data = {24'h000000, CONN_ESTABLISHED};
                     st_nxt.rsp.len  = LEN_BYTE;
                  end else begin
                     st_nxt.rsp.err = 1'b1;
                  end
               end
               default: st_nxt.rsp.err = 1'b1;
            endcase
         end
      end

      // Block sequencer; hard stop abandons the chain at once
      unique case (st_r.seq)
         SEQ_IDLE: begin
            if (start_req) begin
               st_nxt.exec    = 1'b1;
               st_nxt.cur_blk = pwdata[15:8];
               st_nxt.seq     = SEQ_ISSUE;
            end
         end
         SEQ_ISSUE: begin
            st_nxt.mc.valid = 1'b1;
            st_nxt.mc.blk   = st_r.cur_blk;
            st_nxt.mc.code  = code_mem[st_r.cur_blk];
            st_nxt.mc.param = par_mem[st_r.cur_blk];
            st_nxt.seq      = SEQ_WAIT;
         end
         SEQ_WAIT: begin
            if (motion_done) begin
               // Next block with no host traffic
               if (cur_link == LINK_END || 32'(cur_link) > NUM_BLOCKS) begin
                  st_nxt.exec = 1'b0;
                  st_nxt.seq  = SEQ_IDLE;
               end else begin
                  st_nxt.cur_blk = cur_link;
                  st_nxt.seq     = SEQ_ISSUE;
               end
            end
         end
      endcase
      if (st_r.seq != SEQ_IDLE && st_r.cmd0[HARD_STOP_BIT]) begin
         // No block may be issued once busy has dropped
         st_nxt.mc.valid = 1'b0;
         st_nxt.exec     = 1'b0;
         st_nxt.seq      = SEQ_IDLE;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= '0;
         st_r.seq   <= SEQ_IDLE;
         st_r.accel <= ACCEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Block store; writing the code clears the rest of the block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 1; i <= NUM_BLOCKS; i++) begin
            code_mem[i] <= BYTE_RST;
            link_mem[i] <= BYTE_RST;
            par_mem[i]  <= 32'h0000_0000;
         end
      end else if (mem_we) begin
         if (mem_attr == ATTR_BLK_CODE) begin
            code_mem[st_r.req.inst] <= st_r.req.data[7:0];
            link_mem[st_r.req.inst] <= BYTE_RST;
            par_mem[st_r.req.inst]  <= 32'h0000_0000;
         end else if (mem_attr == ATTR_BLK_LINK) begin
            link_mem[st_r.req.inst] <= st_r.req.data[7:0];
         end else begin
            par_mem[st_r.req.inst]  <= st_r.req.data;
         end
      end
   end

   // Outputs straight from flops
   assign prdata     = st_r.prdata;
   assign pready     = st_r.pready;
   assign pslverr    = st_r.pslverr;
   assign motion_cmd = st_r.mc;
   assign block_busy = st_r.exec;

   // ==========================================================
   // Checks
   // Flag follows start
   chk_exec_on_start: assert property (@(posedge pclk) disable iff (!presetn)
      (start_req && st_r.seq == SEQ_IDLE) |=> block_busy ##1 motion_cmd.valid)
      else $error("start did not raise busy and issue");
   chk_issue_code: assert property (@(posedge pclk) disable iff (!presetn)
      motion_cmd.valid |-> motion_cmd.code == code_mem[motion_cmd.blk] && block_busy)
      else $error("issued code differs from block store");
   chk_link_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.seq == SEQ_WAIT && motion_done && cur_link != LINK_END && 32'(cur_link) <= NUM_BLOCKS
       && !st_r.cmd0[HARD_STOP_BIT]) |=> st_r.cur_blk == $past(cur_link))
      else $error("link not followed");
   chk_auto_next: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.seq == SEQ_WAIT && motion_done && cur_link != LINK_END && 32'(cur_link) <= NUM_BLOCKS
       && !st_r.cmd0[HARD_STOP_BIT]) |-> ##2 motion_cmd.valid)
      else $error("next block not issued");
   chk_seq_end: assert property (@(posedge pclk) disable iff (!presetn)
      (st_r.seq == SEQ_WAIT && motion_done && cur_link == LINK_END) |=> !block_busy)
      else $error("busy stayed high after last block");
   chk_rsp_echo: assert property (@(posedge pclk) disable iff (!presetn)
      go |=> st_r.rsp.hdr == $past(st_r.req.hdr) && st_r.rsp.svc == {1'b1, $past(st_r.req.svc[6:0])})
      else $error("response header not echoed");
   chk_pos_read: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_r.req == {8'h00, SVC_GET_SINGLE, CLS_POS_CTRL, INST_ONE, ATTR_CUR_POS, st_r.req.data})
      |=> st_r.rsp.data == $past(cur_position) && st_r.rsp.len == LEN_WORD && !st_r.rsp.err)
      else $error("position read wrong");
   chk_accel_read: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_r.req.cls == CLS_POS_CTRL && st_r.req.inst == INST_ONE && st_r.req.attr == ATTR_ACCEL
       && st_r.req.svc == SVC_GET_SINGLE && !st_r.req.hdr[7]) |=> st_r.rsp.data == $past(st_r.accel))
      else $error("acceleration read wrong");
   chk_blk_lock: assert property (@(posedge pclk) disable iff (!presetn)
      (go && st_r.req.cls == CLS_CMD_BLK && st_r.req.svc == SVC_SET_SINGLE && (st_r.exec || alarm))
      |-> !mem_we ##1 st_r.rsp.err)
      else $error("block change accepted while locked");
   chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready)
      else $error("pready late");

   cov_chain: cover property (@(posedge pclk) disable iff (!presetn)
      motion_cmd.valid ##[1:50] motion_cmd.valid);
   cov_accel: cover property (@(posedge pclk) disable iff (!presetn)
      go && st_r.req.cls == CLS_POS_CTRL && st_r.req.attr == ATTR_ACCEL);
   cov_lock: cover property (@(posedge pclk) disable iff (!presetn)
      go && st_r.req.cls == CLS_CMD_BLK && st_r.exec);

endmodule // fieldbus_block_sequencer

// [tb/motion_engine_model.sv]
// Behavioural motion engine that executes issued command blocks.
// Assumes one pclk domain; the delay input sets prompt or slow completion.
`timescale 1ns/1ns
module motion_engine_model (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire block_seq_pkg::motion_cmd_s motion_cmd,
   input  wire logic [7:0]                delay,
   output logic                           motion_done
);
   import block_seq_pkg::*;
   logic [7:0] cnt_r;

   // ==========================================================
   // Completion timer: one done pulse per issued block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r       <= 8'h00;
         motion_done <= 1'b0;
      end else begin
         motion_done <= (cnt_r == 8'h01);
         if (motion_cmd.valid) begin
            cnt_r <= delay;
         end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
         end
      end
   end
endmodule // motion_engine_model

// [tb/fieldbus_block_sequencer_bench.sv]
// Self-checking bench for the fieldbus block sequencer.
// Assumes the APB map of block_seq_pkg and a motion engine model on the far side.
`timescale 1ns/1ns
module fieldbus_block_sequencer_bench;
   import block_seq_pkg::*;
   typedef struct packed {logic [31:0] head, attr, data, rhead, rdata;} row_s;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, alarm = 0;
   logic        pready, pslverr, motion_done, block_busy, err;
   logic [7:0]  paddr = 8'h00, delay = 8'h3c;
   logic [31:0] pwdata = 32'h0, prdata, rd, cur_position = 32'h00c0ffee;
   motion_cmd_s motion_cmd;
   logic [47:0] seen_q[$];
   int          error_cnt = 0, checks = 0;
   // ==========================================================
   // Explicit requests: head, attribute, data, response head, response data
   row_s rows [0:14] = '{
      '{32'h01251000, 32'h08, 32'h12345678, 32'h00009000, 32'h0},
      '{32'h01250e45, 32'h08, 32'h0, 32'h00048e45, 32'h12345678},
      '{32'h01250e00, 32'h0d, 32'h0, 32'h00048e00, 32'h00c0ffee},
      '{32'h01271000, 32'h01, 32'h09, 32'h00009000, 32'h0},
      '{32'h01271000, 32'h02, 32'h02, 32'h00009000, 32'h0},
      '{32'h01271000, 32'h03, 32'h1f40, 32'h00009000, 32'h0},
      '{32'h02271000, 32'h01, 32'h05, 32'h00009000, 32'h0},
      '{32'h01270e00, 32'h02, 32'h0, 32'h00018e00, 32'h02},
      '{32'h02050e00, 32'h01, 32'h0, 32'h00018e00, 32'h03},
      '{32'h01990e00, 32'h01, 32'h0, 32'h01008e00, 32'h0},
      '{32'hff271000, 32'h01, 32'h07, 32'h00009000, 32'h0},
      '{32'hff270e00, 32'h01, 32'h0, 32'h00018e00, 32'h07},
      '{32'h00270e00, 32'h01, 32'h0, 32'h01008e00, 32'h0},
      '{32'h01250e80, 32'h08, 32'h0, 32'h01008e80, 32'h0},
      '{32'h02040e00, 32'h03, 32'h0, 32'h00028e00, 32'h0}};

   fieldbus_block_sequencer #(.NUM_BLOCKS(255)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cur_position(cur_position), .alarm(alarm), .motion_done(motion_done),
      .motion_cmd(motion_cmd), .block_busy(block_busy));
   motion_engine_model engine (.pclk(pclk), .presetn(presetn), .motion_cmd(motion_cmd),
      .delay(delay), .motion_done(motion_done));

   always #20 pclk = ~pclk;
   // Log every issued block as {block, code, parameter}
   always @(posedge pclk) begin
      if (motion_cmd.valid === 1'b1) seen_q.push_back({motion_cmd.blk, motion_cmd.code, motion_cmd.param});
   end

   // ==========================================================
   // Checking and verdict
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ==========================================================
   // APB master: request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(1, 0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // One explicit request and its response
   task automatic xreq(input row_s r);
      apb(1'b1, REQ_HEAD_OFS, r.head);
      apb(1'b1, REQ_ATTR_OFS, r.attr);
      apb(1'b1, REQ_DATA_OFS, r.data);
      apb(1'b1, REQ_GO_OFS, 32'h0);
      apb(1'b0, RSP_HEAD_OFS, 32'h0);
      chk(rd, r.rhead);
      apb(1'b0, RSP_DATA_OFS, 32'h0);
      chk(rd, r.rdata);
   endtask
   // Block number first, then valid, then start
   task automatic start_seq(input logic [7:0] blk);
      apb(1'b1, CMD_OFS, {16'h0000, blk, 8'h00});
      apb(1'b1, CMD_OFS, {16'h0000, blk, 8'h40});
      apb(1'b1, CMD_OFS, {16'h0000, blk, 8'h42});
   endtask

   // Hang guard: far beyond the under one thousand cycles the tests need
   initial begin
      #2000000;
      error_cnt++;
      test_done;
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(1'b1, 8'h40, 32'h5);
      chk(err, 1'b0);
      foreach (rows[i]) xreq(rows[i]);
      // Start bit without valid data is ignored
      apb(1'b1, CMD_OFS, 32'h0102);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd, 32'h0);
      // Start block 1 by the host sequence; chain then runs alone
      start_seq(8'h01);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd, 32'h0101);
      // Change while executing is refused
      xreq('{32'h01271000, 32'h02, 32'h05, 32'h01009000, 32'h0});
      for (int n = 0; n < 1000 && block_busy !== 1'b0; n++) @(posedge pclk);
      chk(block_busy, 1'b0);
      chk(seen_q.size(), 2);
      chk(seen_q[0], {8'h01, 8'h09, 32'h1f40});
      chk(seen_q[1], {8'h02, 8'h05, 32'h0});
      // Change under alarm is refused
      alarm <= 1'b1;
      xreq('{32'h01271000, 32'h02, 32'h05, 32'h01009000, 32'h0});
      alarm <= 1'b0;
      // Rerun the chain with a prompt engine
      delay <= 8'h01;
      start_seq(8'h01);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[0], 1'b1);
      for (int n = 0; n < 1000 && block_busy !== 1'b0; n++) @(posedge pclk);
      chk(seen_q.size(), 4);
      chk(seen_q[3], {8'h02, 8'h05, 32'h0});
      // Slow engine, hard stop while block 1 still runs: block 2 never issued
      delay <= 8'h3c;
      start_seq(8'h01);
      apb(1'b1, CMD_OFS, 32'h0162);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[0], 1'b0);
      repeat (100) @(posedge pclk);
      chk(seen_q.size(), 5);
      test_done;
   end
endmodule // fieldbus_block_sequencer_bench
